// ===== rtl/atwb_tx_word_builder.sv
module atwb_fifo #(
    parameter int W     = 34,
    parameter int DEPTH = 32
) (
    // Clock and reset.
    input  wire logic         core_clk,
    input  wire logic         reset,
    // Filling side.
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // Draining side.
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0]           wp;
        logic [AW-1:0]           rp;
        logic [AW:0]             cnt;
    } atwb_fifo_t;
    atwb_fifo_t s;
    atwb_fifo_t next_s;
    logic       wr;
    logic       rd;

    assign in_ready  = s.cnt != (AW+1)'(DEPTH);
    assign out_valid = s.cnt != '0;
    assign out_data  = s.mem[s.rp];
    assign wr        = in_valid && in_ready;
    assign rd        = out_valid && out_ready;

    always_comb
    begin
        next_s = s;
        if (wr)
        begin
            next_s.mem[s.wp] = in_data;
            next_s.wp        = s.wp + 1'b1;
        end
        if (rd)
            next_s.rp = s.rp + 1'b1;
        if (wr && !rd)
            next_s.cnt = s.cnt + 1'b1;
        else if (rd && !wr)
            next_s.cnt = s.cnt - 1'b1;
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
            s <= '0;
        else
            s <= next_s;
    end
endmodule : atwb_fifo

module atwb_tx_word_builder #(
    parameter int FIFO_DEPTH      = atwb_pkg::FIFO_DEPTH,
    parameter int REP_TICK_CYCLES = atwb_pkg::REP_TICK_CYCLES
) (
    // Clock and reset.
    input  wire logic             core_clk,
    input  wire logic             reset,
    // Descriptor stream from the sequencer.
    input  wire logic             desc_valid,
    output logic                  desc_ready,
    input  wire logic [2:0]       desc_opcode,
    input  wire logic [4:0]       desc_index,
    input  wire logic [7:0]       desc_value,
    input  wire logic [1:0]       desc_tx_chan,
    // Received-data RAM and fresh flags.
    output logic                  ram_rd_en,
    output logic [12:0]           ram_addr,
    input  wire logic [7:0]       ram_rd_data,
    input  wire logic             fresh_data_for_tx_flag,
    output logic                  fresh_clear,
    // Immediate transmit command.
    input  wire logic             imm_valid,
    input  wire logic [1:0]       imm_chan,
    input  wire logic [31:0]      imm_word,
    // Control.
    input  wire logic             run_pin,
    input  wire logic             master_tx_enable_bit,
    input  wire logic [3:0]       run_bits,
    input  wire logic [3:0][7:0]  rep_interval,
    output logic [3:0]            seq_start,
    // Register read port.
    input  wire logic             reg_rd_en,
    input  wire logic [15:0]      reg_addr,
    output logic [7:0]            reg_rd_data,
    // Transmit word output.
    output logic                  tx_valid,
    input  wire logic             tx_ready,
    output logic [31:0]           tx_word,
    output logic [1:0]            tx_chan
);
    typedef struct packed {
        atwb_pkg::atwb_state_t state;
        logic [1:0]            bidx;
        logic [31:0]           word;
        logic [1:0]            fchan;
        logic                  has_cond;
        logic                  any_fresh;
        logic [2:0]            pend_op;
        logic [7:0]            pend_val;
        logic                  ram_rd_en;
        logic [12:0]           ram_addr;
        logic                  fresh_clear;
        logic                  push_v;
        logic [33:0]           push_data;
        logic [3:0][1:0][31:0] imm;
        logic [3:0]            imm_wp;
        logic [3:0]            imm_rp;
        logic [3:0][1:0]       imm_cnt;
        logic [3:0][1:0]       held;
        logic [3:0]            rdy;
        logic [7:0]            reg_data;
        logic                  out_full;
        logic                  tx_valid;
        logic [34:0]           out_data;
        logic [31:0]           tick_cnt;
        logic [3:0][7:0]       rep_cnt;
        logic [3:0]            run_q;
        logic                  en_q;
        logic [3:0]            seq_start;
    } atwb_top_t;

    atwb_top_t   s;
    atwb_top_t   next_s;
    logic        en;
    logic        imm_any;
    logic [1:0]  imm_ch;
    logic        f_in_valid;
    logic        f_in_ready;
    logic [34:0] f_in_data;
    logic        f_out_valid;
    logic        f_out_ready;
    logic [34:0] f_out_data;
    logic        placed;
    logic        cond;
    logic [7:0]  byte_v;
    logic        drop;
    logic        tick;

    function automatic logic [31:0] put_byte(input logic [31:0] w, input logic [1:0] i,
                                             input logic [7:0] b);
        logic [31:0] r;
        r = w;
        r[8*i +: 8] = b;
        return r;
    endfunction : put_byte

    function automatic logic [1:0] first_busy(input logic [3:0][1:0] cnt);
        logic [1:0] r;
        r = 2'h0;
        for (int c = 3; c >= 0; c--)
            if (cnt[c] != 2'h0)
                r = 2'(c);
        return r;
    endfunction : first_busy

    assign en          = run_pin && master_tx_enable_bit;
    assign imm_any     = s.imm_cnt != '0;
    assign imm_ch      = first_busy(s.imm_cnt);
    // Waiting immediate words win the FIFO slot over the next built word.
    assign f_in_valid  = imm_any || s.push_v;
    // The top bit marks an immediate word, so its buffer slot is freed when it leaves.
    assign f_in_data   = imm_any ? {1'b1, imm_ch, s.imm[imm_ch][s.imm_rp[imm_ch]]}
                                 : {1'b0, s.push_data};
    assign f_out_ready = en && (!s.out_full || (s.tx_valid && tx_ready));
    assign tick        = s.tick_cnt == 32'(REP_TICK_CYCLES - 1);

    assign desc_ready  = s.state[0];
    assign ram_rd_en   = s.ram_rd_en;
    assign ram_addr    = s.ram_addr;
    assign fresh_clear = s.fresh_clear;
    assign seq_start   = s.seq_start;
    assign reg_rd_data = s.reg_data;
    assign tx_valid    = s.tx_valid;
    assign tx_word     = s.out_data[31:0];
    assign tx_chan     = s.out_data[33:32];

    atwb_fifo #(
        .W     (35),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .core_clk  (core_clk),
        .reset     (reset),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    always_comb
    begin
        next_s             = s;
        next_s.ram_rd_en   = 1'b0;
        next_s.fresh_clear = 1'b0;
        next_s.seq_start   = '0;
        placed             = 1'b0;
        cond               = 1'b0;
        byte_v             = 8'h00;
        drop               = 1'b0;

        if (f_in_ready && !imm_any && s.push_v)
            next_s.push_v = 1'b0;

        // Immediate double buffer, two words per channel.
        for (int c = 0; c < atwb_pkg::NUM_CH; c++)
        begin
            logic inc;
            logic dec;
            logic done;
            inc  = imm_valid && imm_chan == 2'(c) && s.held[c] != 2'(atwb_pkg::IMM_SLOTS);
            dec  = f_in_ready && imm_any && imm_ch == 2'(c);
            done = s.tx_valid && tx_ready && s.out_data[34] && s.out_data[33:32] == 2'(c);
            if (inc)
            begin
                next_s.imm[c][s.imm_wp[c]] = imm_word;
                next_s.imm_wp[c]           = ~s.imm_wp[c];
            end
            if (dec)
                next_s.imm_rp[c] = ~s.imm_rp[c];
            if (inc && !dec)
                next_s.imm_cnt[c] = s.imm_cnt[c] + 2'h1;
            else if (dec && !inc)
                next_s.imm_cnt[c] = s.imm_cnt[c] - 2'h1;
            // A word keeps its slot until it has left on the line, not just the buffer.
            if (inc && !done)
                next_s.held[c] = s.held[c] + 2'h1;
            else if (done && !inc)
                next_s.held[c] = s.held[c] - 2'h1;
            next_s.rdy[c] = next_s.held[c] != 2'(atwb_pkg::IMM_SLOTS);
        end

        case (s.state)
            atwb_pkg::S_TAKE:
            begin
                if (desc_valid)
                begin
                    if (s.bidx == 2'h0)
                        next_s.fchan = desc_tx_chan;
                    case (desc_opcode)
                        atwb_pkg::OP_IMM:
                        begin
                            byte_v = desc_value;
                            placed = 1'b1;
                        end
                        atwb_pkg::OP_IMMC, atwb_pkg::OP_IDX, atwb_pkg::OP_IDXC:
                        begin
                            next_s.ram_rd_en = 1'b1;
                            next_s.ram_addr  = {desc_index[4:2], desc_value, desc_index[1:0]};
                            next_s.pend_op   = desc_opcode;
                            next_s.pend_val  = desc_value;
                            next_s.state     = atwb_pkg::S_WAIT;
                        end
                        default:
                        begin
                            // End, no-op and the reserved codes drop the partial word.
                            next_s.bidx      = 2'h0;
                            next_s.has_cond  = 1'b0;
                            next_s.any_fresh = 1'b0;
                        end
                    endcase
                end
            end
            atwb_pkg::S_WAIT:
            begin
                cond   = s.pend_op != atwb_pkg::OP_IDX;
                byte_v = (s.pend_op == atwb_pkg::OP_IMMC) ? s.pend_val : ram_rd_data;
                placed = 1'b1;
                if (cond)
                begin
                    next_s.has_cond    = 1'b1;
                    next_s.any_fresh   = s.any_fresh || fresh_data_for_tx_flag;
                    next_s.fresh_clear = 1'b1;
                end
                next_s.state = atwb_pkg::S_TAKE;
            end
            atwb_pkg::S_PUSH:
            begin
                if (!s.push_v)
                    next_s.state = atwb_pkg::S_TAKE;
            end
            default:
                next_s.state = atwb_pkg::S_TAKE;
        endcase

        if (placed)
        begin
            next_s.word = put_byte(s.word, s.bidx, byte_v);
            next_s.bidx = s.bidx + 2'h1;
            if (s.bidx == 2'h3)
            begin
                drop             = next_s.has_cond && !next_s.any_fresh;
                next_s.has_cond  = 1'b0;
                next_s.any_fresh = 1'b0;
                if (!drop)
                begin
                    next_s.push_v    = 1'b1;
                    next_s.push_data = {s.fchan, next_s.word};
                    next_s.state     = atwb_pkg::S_PUSH;
                end
            end
        end

        // Output stage holds its word while transmission is disabled.
        if (f_out_ready)
        begin
            next_s.out_full = f_out_valid;
            next_s.out_data = f_out_data;
        end
        else if (s.tx_valid && tx_ready)
            next_s.out_full = 1'b0;
        next_s.tx_valid = next_s.out_full && en;

        next_s.reg_data = 8'h00;
        if (reg_rd_en && reg_addr == atwb_pkg::TX_READY_ADDR)
            next_s.reg_data = {4'h0, s.rdy};

        // Repetition scheduling in 10 ms steps.
        next_s.tick_cnt = tick ? 32'h0 : s.tick_cnt + 32'h1;
        next_s.run_q    = run_bits;
        next_s.en_q     = en;
        for (int c = 0; c < atwb_pkg::NUM_CH; c++)
        begin
            if (!run_bits[c])
                next_s.rep_cnt[c] = 8'h00;
            else if (!s.run_q[c] || (en && !s.en_q))
            begin
                next_s.seq_start[c] = en;
                next_s.rep_cnt[c]   = 8'h00;
            end
            else if (tick && rep_interval[c] != 8'h00)
            begin
                if (s.rep_cnt[c] + 8'h01 >= rep_interval[c])
                begin
                    next_s.rep_cnt[c]   = 8'h00;
                    next_s.seq_start[c] = en;
                end
                else
                    next_s.rep_cnt[c] = s.rep_cnt[c] + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (reset)
        begin
            s       <= '0;
            s.state <= atwb_pkg::S_TAKE;
            s.rdy   <= atwb_pkg::TX_READY_RESET;
        end
        else
            s <= next_s;
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);

    sequence s_take(logic [2:0] op);
        desc_valid && desc_ready && desc_opcode == op;
    endsequence

    property p_nop;
        s_take(atwb_pkg::OP_NOP) or s_take(atwb_pkg::OP_END) |=> s.bidx == 2'h0;
    endproperty
    a_nop: assert property (p_nop) else $error("no-op did not drop word");

    property p_imm;
        s_take(atwb_pkg::OP_IMM) and (s.bidx == 2'h1) |=> s.word[15:8] == $past(desc_value);
    endproperty
    a_imm: assert property (p_imm) else $error("value byte misplaced");

    property p_cond_clear;
        s_take(atwb_pkg::OP_IMMC) or s_take(atwb_pkg::OP_IDXC) |=> ram_rd_en ##1 fresh_clear;
    endproperty
    a_cond_clear: assert property (p_cond_clear) else $error("fresh flag not cleared");

    property p_idx_addr;
        s_take(atwb_pkg::OP_IDX) |=> ram_rd_en && ram_addr[9:2] == $past(desc_value)
            && !fresh_clear ##1 !fresh_clear;
    endproperty
    a_idx_addr: assert property (p_idx_addr) else $error("indexed fetch wrong");

    property p_drop;
        drop |=> !s.push_v ##1 !s.push_v;
    endproperty
    a_drop: assert property (p_drop) else $error("stale frame was queued");

    property p_gate;
        $rose(tx_valid) |-> $past(run_pin) && $past(master_tx_enable_bit);
    endproperty
    a_gate: assert property (p_gate) else $error("word sent while disabled");

    property p_status;
        reg_rd_en && reg_addr == atwb_pkg::TX_READY_ADDR
            |=> reg_rd_data == {4'h0, $past(s.rdy)};
    endproperty
    a_status: assert property (p_status) else $error("status read wrong");

    property p_single;
        imm_valid && imm_chan == 2'h0 && s.held[0] == 2'h0 |=> s.rdy[0];
    endproperty
    a_single: assert property (p_single) else $error("ready fell after one word");

    property p_once;
        $rose(run_bits[0]) && en && rep_interval[0] == 8'h00 |=> seq_start[0] ##1 !seq_start[0];
    endproperty
    a_once: assert property (p_once) else $error("one-shot start missing");
endmodule : atwb_tx_word_builder

// ===== rtl/atwb_pkg.sv
package atwb_pkg;
    // Descriptor opcodes.
    localparam logic [2:0] OP_END  = 3'h0;
    localparam logic [2:0] OP_NOP  = 3'h1;
    localparam logic [2:0] OP_IMM  = 3'h2;
    localparam logic [2:0] OP_IMMC = 3'h3;
    localparam logic [2:0] OP_IDX  = 3'h4;
    localparam logic [2:0] OP_IDXC = 3'h5;

    localparam logic [15:0] TX_READY_ADDR  = 16'h800D;
    localparam logic [3:0]  TX_READY_RESET = 4'hF;

    localparam int NUM_CH     = 4;
    localparam int WORD_W     = 32;
    localparam int FIFO_DEPTH = 32;
    localparam int IMM_SLOTS  = 2;

    // Repetition interval step in ms and its length in clock cycles.
    localparam int CLK_MHZ         = 200;
    localparam int REP_TICK_MS     = 10;
    localparam int REP_TICK_CYCLES = CLK_MHZ * 1000 * REP_TICK_MS;

    typedef enum logic [2:0] {
        S_TAKE = 3'b001,
        S_WAIT = 3'b010,
        S_PUSH = 3'b100
    } atwb_state_t;
endpackage : atwb_pkg

// ===== dv/atwb_line_model.sv
module atwb_line_model (
    // Clock.
    input  wire logic        core_clk,
    // Received-data RAM.
    input  wire logic        ram_rd_en,
    input  wire logic [12:0] ram_addr,
    output logic [7:0]       ram_rd_data,
    output logic             fresh_data_for_tx_flag,
    input  wire logic        fresh_clear,
    // Bench control.
    input  wire logic        fresh_set,
    input  wire logic [10:0] fresh_set_blk,
    input  wire logic        stall,
    // Line driver side.
    output logic             tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [2047:0] fresh = '0;
    logic [7:0]    byte_val;
    // Each stored byte follows from its address, so every fetch is predictable.
    assign byte_val = ram_addr[9:2] ^ {ram_addr[12:10], 3'h0, ram_addr[1:0]};
    // Outside a read the bus shows the inverse, so a late sample cannot match.
    assign ram_rd_data = ram_rd_en ? byte_val : ~byte_val;
    assign fresh_data_for_tx_flag = ram_rd_en ~^ fresh[ram_addr[12:2]];
    assign tx_ready = !stall;
    always @(posedge core_clk)
    begin
        if (fresh_set)
            fresh[fresh_set_blk] <= 1'b1;
        if (fresh_clear)
            fresh[ram_addr[12:2]] <= 1'b0;
    end
endmodule : atwb_line_model

// ===== dv/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TICK = 10;
    logic            core_clk, desc_ready, ram_rd_en, fresh_data_for_tx_flag, tx_ready;
    logic            fresh_clear, tx_valid;
    logic            reset = 1'b1, desc_valid = 1'b0, imm_valid = 1'b0, run_pin = 1'b1;
    logic            master_tx_enable_bit = 1'b1, reg_rd_en = 1'b0, fresh_set = 1'b0;
    logic            stall = 1'b0, seeded = 1'b0;
    logic [2:0]      desc_opcode = '0;
    logic [4:0]      desc_index = '0;
    logic [7:0]      desc_value = '0, ram_rd_data, reg_rd_data;
    logic [1:0]      desc_tx_chan = '0, imm_chan = '0, tx_chan;
    logic [12:0]     ram_addr;
    logic [10:0]     fresh_set_blk = '0;
    logic [31:0]     imm_word = '0, tx_word, w;
    logic [3:0]      run_bits = '0, seq_start;
    logic [3:0][7:0] rep_interval = '0, v, e;
    logic [3:0][4:0] ix;
    logic [3:0][2:0] ops;
    logic [15:0]     reg_addr = '0;
    logic [33:0]     exp_q[$];
    int              miscompares = 0, checks_done = 0, n;

    atwb_tx_word_builder #(.REP_TICK_CYCLES(TICK)) i_atwb_tx_word_builder (
        .core_clk, .reset, .desc_valid, .desc_ready, .desc_opcode, .desc_index,
        .desc_value, .desc_tx_chan, .ram_rd_en, .ram_addr, .ram_rd_data,
        .fresh_data_for_tx_flag, .fresh_clear, .imm_valid, .imm_chan, .imm_word,
        .run_pin, .master_tx_enable_bit, .run_bits, .rep_interval, .seq_start,
        .reg_rd_en, .reg_addr, .reg_rd_data, .tx_valid, .tx_ready, .tx_word, .tx_chan);

    atwb_line_model i_atwb_line_model (
        .core_clk, .ram_rd_en, .ram_addr, .ram_rd_data, .fresh_data_for_tx_flag,
        .fresh_clear, .fresh_set, .fresh_set_blk, .stall, .tx_ready);

    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    always @(negedge core_clk)
        stall <= seeded && ($urandom_range(3) == 0);

    task automatic check(string name, logic [33:0] seen, logic [33:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic summarize();
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : summarize

    // Each accepted word is matched against the oldest expectation.
    always @(posedge core_clk)
        if (!reset && tx_valid === 1'b1 && tx_ready === 1'b1)
        begin
            if (exp_q.size() == 0)
                check("unexpected word", 1'b1, 1'b0);
            else
                check("tx word", {tx_chan, tx_word}, exp_q.pop_front());
        end

    function automatic logic [7:0] rb(logic [4:0] i, logic [7:0] lb);
        return lb ^ {i[4:2], 3'h0, i[1:0]};
    endfunction : rb

    task automatic desc(logic [2:0] op, logic [4:0] i, logic [7:0] val, logic [1:0] ch);
        logic rdy;
        @(negedge core_clk);
        desc_valid = 1'b1;
        desc_opcode = op;
        desc_index = i;
        desc_value = val;
        desc_tx_chan = ch;
        for (int k = 0; k < 50; k++)
        begin
            rdy = desc_ready;
            @(posedge core_clk);
            if (rdy)
                break;
            @(negedge core_clk);
        end
    endtask : desc

    task automatic frame(logic [1:0] ch);
        for (int k = 0; k < 4; k++)
            desc(ops[k], ix[k], v[k], ch);
        @(negedge core_clk);
        desc_valid = 1'b0;
    endtask : frame

    task automatic imm(logic [1:0] ch, logic [31:0] wd);
        @(negedge core_clk);
        imm_valid = 1'b1;
        imm_chan = ch;
        imm_word = wd;
        @(negedge core_clk);
        imm_valid = 1'b0;
    endtask : imm

    task automatic rd(logic [15:0] a, logic [7:0] ex, string nm);
        @(negedge core_clk);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge core_clk);
        reg_rd_en = 1'b0;
        check(nm, reg_rd_data, ex);
    endtask : rd

    task automatic setf(logic [10:0] b);
        @(negedge core_clk);
        fresh_set = 1'b1;
        fresh_set_blk = b;
        @(negedge core_clk);
        fresh_set = 1'b0;
    endtask : setf

    task automatic drain();
        for (int k = 0; k < 400 && exp_q.size() != 0; k++)
            @(negedge core_clk);
        check("words left", exp_q.size(), 0);
    endtask : drain

    initial
    begin
        repeat (20000) @(posedge core_clk);
        miscompares++;
        summarize();
    end

    initial
    begin
        void'($urandom(32'h961bede1));
        seeded = 1'b1;
        repeat (4) @(posedge core_clk);
        @(negedge core_clk);
        reset = 1'b0;
        rd(16'h800D, 8'h0F, "ready at reset");
        for (int k = 0; k < 3; k++)
            rd(16'h8000 | 16'($urandom_range(12)), 8'h00, "unmapped");
        for (int c = 0; c < 4; c++)
        begin
            w = $urandom();
            exp_q.push_back({2'(c), w});
            imm(2'(c), w);
        end
        drain();
        ops = {4{atwb_pkg::OP_IMM}};
        v = $urandom();
        ix = $urandom();
        exp_q.push_back({2'h1, v});
        frame(2'h1);
        for (int j = 0; j < 2; j++)
        begin
            desc(atwb_pkg::OP_IMM, 5'h00, 8'hEE, 2'h0);
            desc(atwb_pkg::OP_IMM, 5'h00, 8'hEE, 2'h0);
            desc(j ? atwb_pkg::OP_NOP : atwb_pkg::OP_END, 5'h00, 8'h00, 2'h0);
            v = $urandom();
            exp_q.push_back({2'h3, v});
            frame(2'h3);
        end
        ops = {4{atwb_pkg::OP_IDX}};
        v = $urandom();
        ix = $urandom();
        for (int k = 0; k < 4; k++)
            e[k] = rb(ix[k], v[k]);
        exp_q.push_back({2'h2, e});
        frame(2'h2);
        drain();
        ops = {atwb_pkg::OP_IMM, atwb_pkg::OP_IDX, atwb_pkg::OP_IDXC, atwb_pkg::OP_IMMC};
        v = $urandom();
        ix = $urandom();
        for (int j = 0; j < 3; j++)
        begin
            if (j != 1)
            begin
                setf(j == 0 ? {ix[0][4:2], v[0]} : {ix[1][4:2], v[1]});
                exp_q.push_back({2'h0, v[3], rb(ix[2], v[2]), rb(ix[1], v[1]), v[0]});
            end
            frame(2'h0);
        end
        drain();
        run_pin = 1'b0;
        for (int j = 0; j < 2; j++)
        begin
            w = $urandom();
            exp_q.push_back({2'h2, w});
            imm(2'h2, w);
            repeat (3) @(negedge core_clk);
            rd(16'h800D, j ? 8'h0B : 8'h0F, "ready while held");
        end
        imm(2'h2, $urandom());
        run_pin = 1'b1;
        master_tx_enable_bit = 1'b0;
        repeat (20) @(negedge core_clk);
        master_tx_enable_bit = 1'b1;
        drain();
        rd(16'h800D, 8'h0F, "ready after send");
        run_bits = 4'h1;
        n = 0;
        repeat (100)
        begin
            @(negedge core_clk);
            n += int'(seq_start[0] === 1'b1);
        end
        check("one-shot starts", n, 1);
        rep_interval[1] = 8'h02;
        run_bits = 4'h3;
        // The first periodic start follows the shared tick phase; the next gap is exact.
        for (int j = 0; j < 3; j++)
        begin
            n = 0;
            do
            begin
                @(negedge core_clk);
                n++;
            end
            while (seq_start[1] !== 1'b1 && n < 300);
        end
        check("repeat gap", n, 2 * TICK);
        summarize();
    end
endmodule : tb_top
